/* File: period_match_timer.sv */
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
// Purpose: AXI4-Lite period match timer with sticky interrupt status.
// Assumes: One write and one read in flight at most; data 32 bits.
// Notes:   Unmapped addresses answer SLVERR; reads of them return zero.
module period_match_timer
  import period_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer outputs
  output logic             pwmTimeBase,
  output logic             serialShiftClock,
  output logic             irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  awAddr_reg, awAddr_next;     // Captured write address
  logic        awHave_reg, awHave_next;
  logic [31:0] wData_reg, wData_next;       // Captured write data
  logic        wStrb0_reg, wStrb0_next;     // Low lane enable
  logic        wHave_reg, wHave_next;
  logic        bValid_reg, bValid_next;
  logic [1:0]  bResp_reg, bResp_next;
  logic        rValid_reg, rValid_next;
  logic [1:0]  rResp_reg, rResp_next;
  logic [31:0] rData_reg, rData_next;
  // Register file
  logic [7:0]  period_reg, period_next;     // period_limit
  logic [6:0]  control_reg, control_next;   // timer_control
  logic [7:0]  status_reg, status_next;     // peripheral_irq_flags
  logic [7:0]  mask_reg, mask_next;
  // Output pulses and interrupt line
  logic        irq_reg, irq_next;
  logic        pwm_reg, pwm_next;           // Time base pulse to the PWM unit
  logic        shiftClk_reg, shiftClk_next; // Same pulse offered as a shift clock
  // Channel readies are registered so that no output passes through gates
  logic        awReady_reg, awReady_next;   // Write address slot free
  logic        wReady_reg, wReady_next;     // Write data slot free
  logic        arReady_reg, arReady_next;   // Read answer slot free
  // Write-one-to-clear strobe of the flag register
  logic        statusClear;
  // Core strobes
  logic        counterLoad;
  logic        scalerClear;
  logic        doWrite;
  logic [7:0]  countValue;
  logic        matchPulse;
  logic        postPulse;
  logic [7:0]  wByte;

  // Address map membership
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFF_COUNTER) || (a == OFF_PERIOD) || (a == OFF_CONTROL)
        || (a == OFF_STATUS) || (a == OFF_MASK);
  endfunction

  // ----------------------------------------------------------------
  // Counting chain
  // ----------------------------------------------------------------
  timer_core u_core (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .runEnable   (control_reg[RUN_BIT]),
    .preSelect   (control_reg[PRE_LSB +: 2]),
    .postSelect  (control_reg[POST_LSB +: 4]),
    .periodValue (period_reg),
    .counterLoad (counterLoad),
    .counterData (wByte),
    .scalerClear (scalerClear),
    .countValue  (countValue),
    .matchPulse  (matchPulse),
    .postPulse   (postPulse)
  );

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // Writes commit when both halves are held and the response slot is free
  assign doWrite     = awHave_reg && wHave_reg && !bValid_reg;
  assign wByte       = wData_reg[7:0];
  // A strobe-less write stores nothing and so clears nothing either
  assign counterLoad = doWrite && wStrb0_reg && (awAddr_reg == OFF_COUNTER);
  assign scalerClear = doWrite && wStrb0_reg
                       && ((awAddr_reg == OFF_COUNTER) || (awAddr_reg == OFF_CONTROL));
  // Flag clear request; a match in the same cycle still wins
  assign statusClear = doWrite && wStrb0_reg && (awAddr_reg == OFF_STATUS);

  // ----------------------------------------------------------------
  // Write path and registers
  // ----------------------------------------------------------------
  // One process computes every next value of the write side
  always_comb begin
    awAddr_next  = awAddr_reg;
    awHave_next  = awHave_reg;
    wData_next   = wData_reg;
    wStrb0_next  = wStrb0_reg;
    wHave_next   = wHave_reg;
    bValid_next  = bValid_reg;
    bResp_next   = bResp_reg;
    period_next  = period_reg;
    control_next = control_reg;
    mask_next    = mask_reg;
    status_next  = status_reg;
    // Accept each half independently
    if (s_axi_awvalid && !awHave_reg) begin
      awAddr_next = s_axi_awaddr;
      awHave_next = 1'b1;
    end
    if (s_axi_wvalid && !wHave_reg) begin
      wData_next  = s_axi_wdata;
      wStrb0_next = s_axi_wstrb[0];
      wHave_next  = 1'b1;
    end
    // The response leaves once the master has taken it
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    // Commit: both halves present and the response slot free
    if (doWrite) begin
      awHave_next = 1'b0;
      wHave_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = mapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
      // Only byte lane 0 carries register bits
      if (wStrb0_reg) begin
        if (awAddr_reg == OFF_PERIOD) begin
          period_next = wByte;
        end else if (awAddr_reg == OFF_CONTROL) begin
          control_next = wByte[6:0] & CONTROL_MASK;
        end else if (awAddr_reg == OFF_STATUS) begin
          status_next = status_reg & ~wByte;  // Write one to clear
        end else if (awAddr_reg == OFF_MASK) begin
          mask_next = wByte & STATUS_MASK;
        end
      end
    end
    // A new match outranks a simultaneous clear
    if (postPulse) begin
      status_next[IRQ_BIT] = 1'b1;
    end
    // Readies follow the slot state that the next edge will hold
    awReady_next = !awHave_next;
    wReady_next  = !wHave_next;
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  // One process computes the read answer and the output pulses
  always_comb begin
    rValid_next = rValid_reg;
    rResp_next  = rResp_reg;
    rData_next  = rData_reg;
    // The answer leaves once the master has taken it
    if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
    // A new read is answered on the next edge
    if (s_axi_arvalid && !rValid_reg) begin
      rValid_next = 1'b1;
      rResp_next  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      // Upper bits and unmapped words read as zero
      rData_next  = 32'h0000_0000;
      if (s_axi_araddr == OFF_COUNTER) begin
        rData_next[7:0] = countValue;
      end else if (s_axi_araddr == OFF_PERIOD) begin
        rData_next[7:0] = period_reg;
      end else if (s_axi_araddr == OFF_CONTROL) begin
        rData_next[6:0] = control_reg;
      end else if (s_axi_araddr == OFF_STATUS) begin
        rData_next[7:0] = status_reg;
      end else if (s_axi_araddr == OFF_MASK) begin
        rData_next[7:0] = mask_reg;
      end
    end
    // A held answer blocks the next read address until it is taken
    arReady_next  = !rValid_next;
    // Built from the next flags so the line moves with them
    irq_next      = |(status_next & mask_next);
    // Both consumers see the same one-cycle match pulse
    pwm_next      = matchPulse;
    shiftClk_next = matchPulse;
  end

  // Registers only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // Bus side empty, nothing held or answered
      awAddr_reg  <= 8'h00;
      awHave_reg  <= 1'b0;
      wData_reg   <= 32'h0000_0000;
      wStrb0_reg  <= 1'b0;
      wHave_reg   <= 1'b0;
      bValid_reg  <= 1'b0;
      bResp_reg   <= RESP_OKAY;
      rValid_reg  <= 1'b0;
      rResp_reg   <= RESP_OKAY;
      rData_reg   <= 32'h0000_0000;
      // Register file to its reset state
      period_reg  <= PERIOD_RST;
      control_reg <= CONTROL_RST;
      status_reg  <= 8'h00;
      mask_reg    <= 8'h00;
      irq_reg     <= 1'b0;
      pwm_reg     <= 1'b0;
      shiftClk_reg <= 1'b0;
      awReady_reg  <= 1'b1;  // Slots start empty and so ready
      wReady_reg   <= 1'b1;
      arReady_reg  <= 1'b1;
    end else begin
      // Every register moves on every edge
      awAddr_reg  <= awAddr_next;
      awHave_reg  <= awHave_next;
      wData_reg   <= wData_next;
      wStrb0_reg  <= wStrb0_next;
      wHave_reg   <= wHave_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      rValid_reg  <= rValid_next;
      rResp_reg   <= rResp_next;
      rData_reg   <= rData_next;
      period_reg  <= period_next;
      control_reg <= control_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      irq_reg     <= irq_next;
      pwm_reg     <= pwm_next;
      shiftClk_reg <= shiftClk_next;
      awReady_reg  <= awReady_next;
      wReady_reg   <= wReady_next;
      arReady_reg  <= arReady_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from its register
  // ----------------------------------------------------------------
  assign s_axi_awready    = awReady_reg;
  assign s_axi_wready     = wReady_reg;
  assign s_axi_bvalid     = bValid_reg;
  assign s_axi_bresp      = bResp_reg;
  assign s_axi_arready    = arReady_reg;
  assign s_axi_rvalid     = rValid_reg;
  assign s_axi_rresp      = rResp_reg;
  assign s_axi_rdata      = rData_reg;
  assign pwmTimeBase      = pwm_reg;
  assign serialShiftClock = shiftClk_reg;
  assign irq              = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_flag_sets: assert property (@(posedge clock) disable iff (sys_rst)
    postPulse |=> status_reg[IRQ_BIT])
    else $error("match flag not set");
  a_ctrl_keeps_count: assert property (@(posedge clock) disable iff (sys_rst)
    (doWrite && awAddr_reg == OFF_CONTROL && !control_reg[RUN_BIT]) |=> $stable(countValue))
    else $error("control write changed counter");
  a_bit7_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (rValid_reg && $rose(rValid_reg) && $past(s_axi_araddr) == OFF_CONTROL) |-> !s_axi_rdata[7])
    else $error("control bit 7 not zero");
  a_pwm_follows: assert property (@(posedge clock) disable iff (sys_rst)
    matchPulse |=> pwmTimeBase && serialShiftClock)
    else $error("time base not driven");
  a_load_count: assert property (@(posedge clock) disable iff (sys_rst)
    counterLoad |=> (countValue == $past(wByte)))
    else $error("counter write lost");
  a_ready_tracks: assert property (@(posedge clock) disable iff (sys_rst)
    (s_axi_awready == !awHave_reg) && (s_axi_wready == !wHave_reg) && (s_axi_arready == !rValid_reg))
    else $error("channel ready out of step");
  a_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    (status_reg[IRQ_BIT] && !statusClear) |=> status_reg[IRQ_BIT])
    else $error("match flag lost without clear");
  a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
    irq == |(status_reg & mask_reg))
    else $error("interrupt line disagrees with flags");
  // Main scenarios reached
  c_irq: cover property (@(posedge clock) disable iff (sys_rst) irq);
  c_write: cover property (@(posedge clock) disable iff (sys_rst) doWrite);
  c_read: cover property (@(posedge clock) disable iff (sys_rst) rValid_reg && s_axi_rready);
endmodule

/* File: period_timer_pkg.sv */
// Purpose: Constants for the period match timer and its register map.
// Assumes: AXI4-Lite register access, one 20 MHz clock.
// Notes:   All offsets are byte addresses of aligned 32-bit words.
//
// Notes on behaviour
// - Counter and period both read/write
// - Count input is system clock over four
// - Prescale 1, 4, 16 by bits 1:0
// - Postscale 1..16 by bits 6:3
// - Postscaler output sets match interrupt flag
// - Control bit 2 enables counting
// - Reset clears counter to zero
// - Counter/control write or reset clears scalers
// - Control write keeps counter value
// - Match pulse offered as PWM time base
// - Match output offered as serial shift clock
package period_timer_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_COUNTER = 8'h00;  // tick_counter
  localparam logic [7:0] OFF_PERIOD  = 8'h04;  // period_limit
  localparam logic [7:0] OFF_CONTROL = 8'h08;  // timer_control
  localparam logic [7:0] OFF_STATUS  = 8'h0c;  // peripheral_irq_flags
  localparam logic [7:0] OFF_MASK    = 8'h10;  // interrupt mask
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         RUN_BIT      = 2;
  localparam int         PRE_LSB      = 0;
  localparam int         POST_LSB     = 3;
  localparam int         IRQ_BIT      = 1;
  localparam logic [6:0] CONTROL_MASK = 7'h7f;
  localparam logic [7:0] COUNTER_RST  = 8'h00;
  localparam logic [7:0] PERIOD_RST   = 8'hff;
  localparam logic [6:0] CONTROL_RST  = 7'h00;
  localparam logic [7:0] STATUS_MASK  = 8'h02;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;   // oscillator over four
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // Prescale code to terminal count
  function automatic logic [3:0] preLast(input logic [1:0] sel);
    if (sel == 2'h0) begin
      return 4'h0;
    end else if (sel == 2'h1) begin
      return 4'h3;
    end else begin
      return 4'hf;
    end
  endfunction
endpackage

/* File: timer_core.sv */
`timescale 1ns/1ps
// Purpose: Count chain: divide by four, prescaler, counter, postscaler.
// Assumes: Loads and clears are single-cycle pulses from the register file.
// Notes:   Match and flag pulses are one cycle wide.
module timer_core
  import period_timer_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       runEnable,
  input  wire logic [1:0] preSelect,
  input  wire logic [3:0] postSelect,
  input  wire logic [7:0] periodValue,
  input  wire logic       counterLoad,
  input  wire logic [7:0] counterData,
  input  wire logic       scalerClear,
  // Results
  output logic      [7:0] countValue,
  output logic            matchPulse,
  output logic            postPulse
);
  logic [1:0] quarter_reg, quarter_next;  // Instruction-cycle divider
  logic [3:0] pre_reg, pre_next;          // Prescale count
  logic [3:0] post_reg, post_next;        // Postscale count
  logic [7:0] cnt_reg, cnt_next;          // Counter
  logic       match_reg, match_next;
  logic       postOut_reg, postOut_next;  // Postscaler output pulse
  logic       tick;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    quarter_next  = quarter_reg;
    pre_next      = pre_reg;
    post_next     = post_reg;
    cnt_next      = cnt_reg;
    match_next    = 1'b0;
    postOut_next  = 1'b0;
    tick          = 1'b0;
    if (runEnable) begin
      quarter_next = quarter_reg + 2'h1;
      if (quarter_reg == INSTR_DIV_LAST) begin
        if (pre_reg >= preLast(preSelect)) begin
          pre_next = 4'h0;
          tick     = 1'b1;
        end else begin
          pre_next = pre_reg + 4'h1;
        end
      end
    end
    if (tick) begin
      if (cnt_reg == periodValue) begin
        cnt_next   = COUNTER_RST;
        match_next = 1'b1;
        if (post_reg >= postSelect) begin
          post_next     = 4'h0;
          postOut_next  = 1'b1;
        end else begin
          post_next = post_reg + 4'h1;
        end
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
    // Write clears scalers; the counter still moves on a tick in the same cycle or on its own load
    if (scalerClear) begin
      pre_next      = 4'h0;
      post_next     = 4'h0;
      quarter_next  = 2'h0;
      postOut_next  = 1'b0;
    end
    if (counterLoad) begin
      cnt_next   = counterData;
      match_next = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      quarter_reg  <= 2'h0;
      pre_reg      <= 4'h0;
      post_reg     <= 4'h0;
      cnt_reg      <= COUNTER_RST;
      match_reg    <= 1'b0;
      postOut_reg  <= 1'b0;
    end else begin
      quarter_reg  <= quarter_next;
      pre_reg      <= pre_next;
      post_reg     <= post_next;
      cnt_reg      <= cnt_next;
      match_reg    <= match_next;
      postOut_reg  <= postOut_next;
    end
  end

  assign countValue = cnt_reg;
  assign matchPulse = match_reg;
  assign postPulse  = postOut_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stop_holds: assert property (@(posedge clock) disable iff (sys_rst)
    (!runEnable && !counterLoad) |=> (cnt_reg == $past(cnt_reg)))
    else $error("counter moved while stopped");
  a_match_wraps: assert property (@(posedge clock) disable iff (sys_rst)
    match_reg |-> (cnt_reg == COUNTER_RST))
    else $error("match without counter wrap");
  a_post_needs_match: assert property (@(posedge clock) disable iff (sys_rst)
    postOut_reg |-> match_reg)
    else $error("postscaler fired without match");
  a_clear_scalers: assert property (@(posedge clock) disable iff (sys_rst)
    scalerClear |=> (pre_reg == 4'h0 && post_reg == 4'h0))
    else $error("scalers not cleared");
  a_tick_spacing: assert property (@(posedge clock) disable iff (sys_rst)
    (runEnable && quarter_reg == 2'h0 && !scalerClear) |=> (quarter_reg == 2'h1))
    else $error("instruction divider did not advance");
  c_match: cover property (@(posedge clock) disable iff (sys_rst) match_reg);
  c_post: cover property (@(posedge clock) disable iff (sys_rst) postOut_reg);
endmodule

/* File: period_match_timer_tb.sv */
// Purpose: Self-checking bench for the period match timer over AXI4-Lite.
// Assumes: One 20 MHz clock; the bench waits for every bus answer.
// Notes:   Short periods keep each match interval to a few hundred cycles.
`timescale 1ns/1ps
module period_match_timer_tb
  import period_timer_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clock;      // 20 MHz clock
  logic        sysRst;     // Sync reset, active high
  logic [7:0]  awAddr;     // Write address channel
  logic        awValid;
  logic        awReady;
  logic [31:0] wData;      // Write data channel
  logic [3:0]  wStrb;
  logic        wValid;
  logic        wReady;
  logic [1:0]  bResp;      // Write response channel
  logic        bValid;
  logic        bReady;
  logic [7:0]  arAddr;     // Read address channel
  logic        arValid;
  logic        arReady;
  logic [31:0] rData;      // Read data channel
  logic [1:0]  rResp;
  logic        rValid;
  logic        rReady;
  logic        pwmBase;    // Match pulse to the PWM unit
  logic        shiftClk;   // Match pulse to the serial port
  logic        irq;        // Level interrupt
  int          numErrors;  // Mismatches
  int          nCompared;  // Comparisons

  // Half period of 25 ns gives 20 MHz
  initial clock = 1'b0;
  always #25 clock = ~clock;

  period_match_timer i_dut (
    .clock(clock), .sys_rst(sysRst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .pwmTimeBase(pwmBase), .serialShiftClock(shiftClk), .irq(irq)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Compare and count; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone  = 1'b0;
    @(posedge clock);
    awAddr  <= a;
    awValid <= 1'b1;
    wData   <= d;
    wStrb   <= s;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (awValid && awReady === 1'b1) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady === 1'b1) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge clock); while (bValid !== 1'b1);
    bReady <= 1'b0;
    chk({30'h0, bResp}, {30'h0, er});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axiWrite(a, d, 4'hf, RESP_OKAY);
  endtask

  // Read: response code checked here, data handed back
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] got);
    @(posedge clock);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do @(posedge clock); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge clock); while (rValid !== 1'b1);
    rReady <= 1'b0;
    got = rData;
    chk({30'h0, rResp}, {30'h0, er});
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, RESP_OKAY, v);
    chk(v, exp);
  endtask

  // Cycles up to the next match pulse; both timer outputs must agree
  task automatic waitPulse(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pwmBase !== 1'b1 && n < 3000);
    chk({31'h0, shiftClk}, {31'h0, pwmBase});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic testReset();
    rdChk(OFF_COUNTER, 32'h00);
    rdChk(OFF_PERIOD, 32'hff);
    rdChk(OFF_CONTROL, 32'h00);
    rdChk(OFF_STATUS, 32'h00);
    rdChk(OFF_MASK, 32'h00);
    wr(OFF_COUNTER, 32'h44);
    wr(OFF_CONTROL, 32'h7b);
    @(posedge clock);
    sysRst <= 1'b1;
    repeat (2) @(posedge clock);
    sysRst <= 1'b0;
    rdChk(OFF_COUNTER, 32'h00);
    rdChk(OFF_CONTROL, 32'h00);
  endtask

  task automatic testRegs();
    logic [31:0] v;
    wr(OFF_PERIOD, 32'hffffff5a);
    rdChk(OFF_PERIOD, 32'h5a);
    wr(OFF_COUNTER, 32'ha5);
    rdChk(OFF_COUNTER, 32'ha5);
    wr(OFF_CONTROL, 32'hfb);
    rdChk(OFF_CONTROL, 32'h7b);
    wr(OFF_CONTROL, 32'h00);
    axiWrite(OFF_PERIOD, 32'h11, 4'he, RESP_OKAY);
    rdChk(OFF_PERIOD, 32'h5a);
    // Unmapped word answers an error both ways and reads zero
    axiWrite(8'h14, 32'h1, 4'hf, RESP_SLVERR);
    rd(8'h14, RESP_SLVERR, v);
    chk(v, 32'h0);
  endtask

  // Interval = (period + 1) ticks of four clocks times the prescale
  task automatic testPrescale();
    int n;
    int div;
    wr(OFF_PERIOD, 32'h02);
    for (int c = 0; c < 4; c++) begin
      div = (c == 0) ? 1 : ((c == 1) ? 4 : 16);
      wr(OFF_CONTROL, 32'h04 | c);
      waitPulse(n);
      waitPulse(n);
      chk(n, 3 * 4 * div);
    end
  endtask

  // Flag rises after postscale + 1 matches; irq follows only when unmasked
  task automatic testPostscale();
    int cnt;
    int p;
    wr(OFF_PERIOD, 32'h07);
    wr(OFF_MASK, 32'h02);
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 0 : ((i == 1) ? 1 : 15);
      wr(OFF_CONTROL, 32'h00);
      wr(OFF_STATUS, 32'h02);
      wr(OFF_COUNTER, 32'h00);
      wr(OFF_CONTROL, (p << 3) | 32'h04);
      cnt = 0;
      for (int k = 0; k < 2000 && irq !== 1'b1; k++) begin
        @(posedge clock);
        if (pwmBase === 1'b1) cnt++;
      end
      chk(cnt, p + 1);
    end
    wr(OFF_CONTROL, 32'h00);
    rdChk(OFF_STATUS, 32'h02);
    wr(OFF_STATUS, 32'h02);
    rdChk(OFF_STATUS, 32'h00);
    chk({31'h0, irq}, 32'h0);
    // Masked: flag still latches, line stays low
    wr(OFF_MASK, 32'h00);
    wr(OFF_CONTROL, 32'h04);
    repeat (100) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rdChk(OFF_STATUS, 32'h02);
    wr(OFF_CONTROL, 32'h00);
    wr(OFF_STATUS, 32'h02);
  endtask

  task automatic testRunHold();
    logic [31:0] v;
    wr(OFF_PERIOD, 32'hff);
    wr(OFF_COUNTER, 32'h33);
    repeat (60) @(posedge clock);
    rdChk(OFF_COUNTER, 32'h33);
    // A stopped timer must leave both pulse outputs low
    chk({30'h0, pwmBase, shiftClk}, 32'h0);
    wr(OFF_CONTROL, 32'h04);
    repeat (40) @(posedge clock);
    wr(OFF_CONTROL, 32'h03);
    rd(OFF_COUNTER, RESP_OKAY, v);
    chk({31'h0, v > 32'h33}, 32'h1);
    wr(OFF_CONTROL, 32'h00);
    rdChk(OFF_COUNTER, v);
  endtask

  // A mid-prescale write restarts the full 16 x 4 clock wait
  task automatic testScalerClear();
    int n;
    wr(OFF_PERIOD, 32'h05);
    wr(OFF_COUNTER, 32'h05);
    wr(OFF_CONTROL, 32'h06);
    repeat (37) @(posedge clock);
    wr(OFF_CONTROL, 32'h06);
    waitPulse(n);
    chk({31'h0, n >= 52 && n <= 70}, 32'h1);
    repeat (37) @(posedge clock);
    wr(OFF_COUNTER, 32'h05);
    waitPulse(n);
    chk({31'h0, n >= 52 && n <= 70}, 32'h1);
    wr(OFF_CONTROL, 32'h00);
  endtask

  // ------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic endSim();
    if (numErrors == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run needs a few thousand cycles; this is a generous bound
  initial begin
    repeat (30000) @(posedge clock);
    numErrors++;
    endSim();
  end

  initial begin
    sysRst = 1'b1;
    awAddr = 8'h00;
    awValid = 1'b0;
    wData = 32'h0;
    wStrb = 4'h0;
    wValid = 1'b0;
    bReady = 1'b0;
    arAddr = 8'h00;
    arValid = 1'b0;
    rReady = 1'b0;
    numErrors = 0;
    nCompared = 0;
    repeat (2) @(posedge clock);
    sysRst <= 1'b0;
    testReset();
    testRegs();
    testPrescale();
    testPostscale();
    testRunHold();
    testScalerClear();
    endSim();
  end
endmodule
